// File: include/drb_pkg.sv
// Package of constants for the diagnostic record bank
// Operation
// [R1] No diagnostic interrupt; record read on demand
// [R2] Channel error lights LED and is recorded
// [R3] Record set 01h full, 00h first four
// [R4] Index 2F01h full, 2F00h first four
// [R5] Index 5005h, subindex 02h onward per byte
// [R6] Summary bits: failure, internal, external, channel
// [R7] Summary bit4 aux supply, bit7 parameter error
// [R8] Module info: class 0101b, bit4 channel info
// [R9] Internal byte: bit3 overflow, bit4 communication
// [R10] Channel kind byte reports analog input 71h
// [R11] Bit count byte constant 08h
// [R12] Channel count byte constant 04h
// [R13] Group byte bits 0-3 per channel group
// [R14] Channel byte: bit0 config, bit6 under, bit7 over
// [R15] Event captures microsecond ticker into timestamp
// [R16] Ticker zero at reset, one step per microsecond
// [R17] 32-bit ticker wraps to zero
// [R18] Reserved bits and bytes read zero
// [R19] Channel and group bits OR channel flags
package drb_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam logic [7:0] RECORD_FULL = 8'h01;
  localparam logic [7:0] RECORD_SHORT = 8'h00;
  localparam logic [15:0] INDEX_FULL = 16'h2F01;
  localparam logic [15:0] INDEX_SHORT = 16'h2F00;
  localparam logic [15:0] INDEX_FIELDBUS = 16'h5005;
  localparam logic [7:0] SUBINDEX_FIRST = 8'h02;
  localparam logic [4:0] RECORD_BYTES = 5'h14;
  localparam logic [4:0] SHORT_BYTES = 5'h04;
  localparam logic [4:0] OFS_SUMMARY = 5'h00;
  localparam logic [4:0] OFS_MODINFO = 5'h01;
  localparam logic [4:0] OFS_INTERNAL = 5'h03;
  localparam logic [4:0] OFS_KIND = 5'h04;
  localparam logic [4:0] OFS_BITCOUNT = 5'h05;
  localparam logic [4:0] OFS_CHCOUNT = 5'h06;
  localparam logic [4:0] OFS_GROUP = 5'h07;
  localparam logic [4:0] OFS_CHAN0 = 5'h08;
  localparam logic [4:0] OFS_STAMP = 5'h10;
  localparam logic [7:0] MODINFO_VALUE = 8'h15;
  localparam logic [7:0] KIND_VALUE = 8'h71;
  localparam logic [7:0] BITCOUNT_VALUE = 8'h08;
  localparam logic [7:0] CHCOUNT_VALUE = 8'h04;
  localparam int SUM_FAIL = 0;
  localparam int SUM_INTERNAL = 1;
  localparam int SUM_EXTERNAL = 2;
  localparam int SUM_CHANNEL = 3;
  localparam int SUM_AUX = 4;
  localparam int SUM_PARAM = 7;
  localparam int INT_OVERFLOW = 3;
  localparam int INT_COMM = 4;
  localparam int CH_CONFIG = 0;
  localparam int CH_UNDER = 6;
  localparam int CH_OVER = 7;
  localparam int NUM_CH = 4;
endpackage

// File: verilog/drb_ticker.sv
// Free-running 32-bit microsecond ticker
`timescale 1ns/1ps
`default_nettype none
module drb_ticker (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  output logic [31:0] o_ticks
);
  logic [4:0] div_reg;
  logic tick_en;
  assign tick_en = (div_reg == 5'(drb_pkg::TICK_CYCLES - 1));
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      div_reg <= 5'h00; // [R16]
      o_ticks <= 32'h00000000; // [R16]
    end else begin
      div_reg <= tick_en ? 5'h00 : div_reg + 5'h01;
      if (tick_en) begin
        o_ticks <= o_ticks + 32'h00000001; // [R17]
      end
    end
  end
endmodule // drb_ticker
`default_nettype wire

// File: verilog/drb_addr_map.sv
// Maps record set, object index or subindex to a byte offset
`timescale 1ns/1ps
`default_nettype none
module drb_addr_map (
  input wire logic [1:0] i_mode,
  input wire logic [15:0] i_key,
  input wire logic [7:0] i_sub,
  output logic o_hit,
  output logic [4:0] o_offset
);
  logic [4:0] lim;
  logic [7:0] rel;
  logic [7:0] pos;
  logic set_ok;
  logic index_ok;
  logic sub_ok;
  assign set_ok = (i_key[7:0] == drb_pkg::RECORD_FULL) || (i_key[7:0] == drb_pkg::RECORD_SHORT); // [R3]
  assign index_ok = (i_key == drb_pkg::INDEX_FULL) || (i_key == drb_pkg::INDEX_SHORT); // [R4]
  assign sub_ok = (i_key == drb_pkg::INDEX_FIELDBUS) && (i_sub >= drb_pkg::SUBINDEX_FIRST); // [R5]
  assign rel = i_sub - drb_pkg::SUBINDEX_FIRST; // [R5]
  // Full byte position; upper bits must not alias into the record
  assign pos = (i_mode == 2'h2) ? rel : i_sub;
  assign lim = ((i_mode == 2'h0 && i_key[7:0] == drb_pkg::RECORD_SHORT)
             || (i_mode == 2'h1 && i_key == drb_pkg::INDEX_SHORT)) ? drb_pkg::SHORT_BYTES : drb_pkg::RECORD_BYTES;
  assign o_offset = pos[4:0];
  assign o_hit = ((i_mode == 2'h0 && set_ok && i_key[15:8] == 8'h00) || (i_mode == 2'h1 && index_ok)
               || (i_mode == 2'h2 && sub_ok)) && (pos < {3'h0, lim});
endmodule // drb_addr_map
`default_nettype wire

// File: verilog/drb_bank.sv
// Diagnostic record bank with byte read port
`timescale 1ns/1ps
`default_nettype none
module drb_bank (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_module_fail,
  input wire logic i_internal_err,
  input wire logic i_external_err,
  input wire logic i_aux_missing,
  input wire logic i_param_err,
  input wire logic i_buffer_overflow,
  input wire logic i_comm_err,
  input wire logic [3:0] i_ch_config_err,
  input wire logic [3:0] i_ch_underflow,
  input wire logic [3:0] i_ch_overflow,
  input wire logic i_rd_req,
  input wire logic [1:0] i_access_mode,
  input wire logic [15:0] i_access_key,
  input wire logic [7:0] i_access_sub,
  output logic o_rd_valid,
  output logic o_rd_error,
  output logic [7:0] o_rd_data,
  output logic [3:0] o_ch_led
);
  logic [31:0] ticks;
  logic [7:0] summary_error_byte;
  logic [7:0] internal_error_byte;
  logic [7:0] group_error_byte;
  logic [7:0] chan_err [4];
  logic [31:0] diag_timestamp_reg;
  logic [7:0] state_reg;
  logic [7:0] state_next;
  logic event_now;
  logic hit;
  logic [4:0] offset;
  logic [7:0] byte_sel;
  logic [7:0] stamp_byte;
  logic [3:0] ch_any;
  drb_ticker u_ticker (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .o_ticks(ticks)
  );
  drb_addr_map u_map (
    .i_mode(i_access_mode),
    .i_key(i_access_key),
    .i_sub(i_access_sub),
    .o_hit(hit),
    .o_offset(offset)
  );
  genvar g;
  for (g = 0; g < drb_pkg::NUM_CH; g++) begin : g_ch
    assign chan_err[g] = {i_ch_overflow[g], i_ch_underflow[g], 5'h00, i_ch_config_err[g]}; // [R14] [R18]
    assign ch_any[g] = |chan_err[g]; // [R19]
  end
  assign group_error_byte = {4'h0, ch_any}; // [R13] [R18]
  assign summary_error_byte = {i_param_err, 2'h0, i_aux_missing, |ch_any, i_external_err,
                               i_internal_err, i_module_fail}; // [R6] [R7] [R19]
  assign internal_error_byte = {3'h0, i_comm_err, i_buffer_overflow, 3'h0}; // [R9] [R18]
  assign o_ch_led = ch_any; // [R2]
  // Snapshot of summary byte OR internal byte; a new set bit in it is a diagnostic event
  assign state_next = summary_error_byte | internal_error_byte;
  assign event_now = |(state_next & ~state_reg);
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= 8'h00;
      diag_timestamp_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      if (event_now) begin
        diag_timestamp_reg <= ticks; // [R15] [R2]
      end
    end
  end
  assign stamp_byte = diag_timestamp_reg[8 * offset[1:0] +: 8];
  assign byte_sel = (offset == drb_pkg::OFS_SUMMARY) ? summary_error_byte :
                    (offset == drb_pkg::OFS_MODINFO) ? drb_pkg::MODINFO_VALUE : // [R8]
                    (offset == drb_pkg::OFS_INTERNAL) ? internal_error_byte :
                    (offset == drb_pkg::OFS_KIND) ? drb_pkg::KIND_VALUE : // [R10]
                    (offset == drb_pkg::OFS_BITCOUNT) ? drb_pkg::BITCOUNT_VALUE : // [R11]
                    (offset == drb_pkg::OFS_CHCOUNT) ? drb_pkg::CHCOUNT_VALUE : // [R12]
                    (offset == drb_pkg::OFS_GROUP) ? group_error_byte :
                    (offset[4:2] == 3'h2) ? chan_err[offset[1:0]] :
                    (offset[4:2] == 3'h4) ? stamp_byte : 8'h00; // [R18]
  // Read answer one cycle after request; no interrupt output exists
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rd_valid <= 1'b0;
      o_rd_error <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_rd_valid <= i_rd_req & hit; // [R1] [R3] [R4] [R5]
      o_rd_error <= i_rd_req & ~hit;
      o_rd_data <= (i_rd_req & hit) ? byte_sel : 8'h00;
    end
  end
endmodule // drb_bank
`default_nettype wire

// File: sim/drb_host.sv
// Head-station model issuing byte reads
`timescale 1ns/1ps
`default_nettype none
module drb_host (
  input wire logic i_clk_sys,
  input wire logic i_rd_error,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_req = 1'b0,
  output logic [1:0] o_mode = 2'h3,
  output logic [15:0] o_key = 16'h0000,
  output logic [7:0] o_sub = 8'h00
);
  task automatic rd(input logic [1:0] m, input logic [15:0] k, input logic [7:0] s, output logic e,
    output logic [7:0] d);
    @(posedge i_clk_sys);
    o_rd_req <= 1'b1;
    o_mode <= m;
    o_key <= k;
    o_sub <= s;
    @(posedge i_clk_sys);
    o_rd_req <= 1'b0;
    o_key <= ~k;
    o_sub <= ~s;
    @(posedge i_clk_sys);
    e = i_rd_error;
    d = i_rd_data;
  endtask
endmodule // drb_host
`default_nettype wire

// File: sim/drb_sva.sv
// Checker for the diagnostic record bank
`timescale 1ns/1ps
`default_nettype none
module drb_sva (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [3:0] i_ch_config_err,
  input wire logic [3:0] i_ch_underflow,
  input wire logic [3:0] i_ch_overflow,
  input wire logic i_rd_req,
  input wire logic [1:0] i_access_mode,
  input wire logic [15:0] i_access_key,
  input wire logic [7:0] i_access_sub,
  input wire logic o_rd_valid,
  input wire logic o_rd_error,
  input wire logic [7:0] o_rd_data,
  input wire logic [3:0] o_ch_led
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire logic rq0 = i_rd_req && i_access_mode == 2'h0;
  wire logic full = rq0 && i_access_key == 16'h0001;
  one_answer_a: assert property (i_rd_req |=> o_rd_valid != o_rd_error) else $error("No single answer");
  no_answer_a: assert property (!i_rd_req |=> !o_rd_valid && !o_rd_error) else $error("Stray answer");
  led_or_a: assert property (o_ch_led == (i_ch_config_err | i_ch_underflow | i_ch_overflow)) else $error("LED");
  kind_byte_a: assert property (full && i_access_sub == 8'h04 |=> o_rd_data == 8'h71) else $error("Kind");
  count_byte_a: assert property (full && i_access_sub == 8'h06 |=> o_rd_data == 8'h04) else $error("Count");
  idle_zero_a: assert property (!o_rd_valid |-> o_rd_data == 8'h00) else $error("Idle data");
  short_len_a: assert property (rq0 && i_access_key == 16'h0000 && i_access_sub > 8'h03 |=> o_rd_error)
    else $error("Short read");
  sub_low_a: assert property (i_rd_req && i_access_mode == 2'h2 && i_access_sub < 8'h02 |=> o_rd_error)
    else $error("Subindex");
  cover property (i_rd_req ##1 o_rd_error);
  cover property (o_rd_valid && o_rd_data == 8'h71);
  cover property (o_ch_led != 4'h0);
endmodule // drb_sva
bind drb_bank drb_sva i_sva (.i_clk_sys, .i_reset, .i_ch_config_err, .i_ch_underflow, .i_ch_overflow, .i_rd_req,
  .i_access_mode, .i_access_key, .i_access_sub, .o_rd_valid, .o_rd_error, .o_rd_data, .o_ch_led);
`default_nettype wire

// File: sim/drb_bank_test.sv
// Self-checking bench for the diagnostic record bank
`timescale 1ns/1ps
`default_nettype none
module drb_bank_test;
  logic i_clk_sys = 1'b0, i_reset = 1'b1, req, err, vld, e;
  logic [6:0] flg = 7'h00;
  logic [3:0] cfg = 4'h0, und = 4'h0, ovr = 4'h0, led;
  logic [1:0] mode;
  logic [15:0] key;
  logic [7:0] sub, dat, d;
  logic [31:0] ts;
  int fails = 0, check_count = 0, cyc = 0, t0;
  drb_bank i_dut (.i_clk_sys, .i_reset, .i_module_fail(flg[0]), .i_internal_err(flg[1]), .i_external_err(flg[2]),
    .i_aux_missing(flg[3]), .i_param_err(flg[4]), .i_buffer_overflow(flg[5]), .i_comm_err(flg[6]),
    .i_ch_config_err(cfg), .i_ch_underflow(und), .i_ch_overflow(ovr), .i_rd_req(req), .i_access_mode(mode),
    .i_access_key(key), .i_access_sub(sub), .o_rd_valid(vld), .o_rd_error(err), .o_rd_data(dat), .o_ch_led(led));
  drb_host i_host (.i_clk_sys, .i_rd_error(err), .i_rd_data(dat), .o_rd_req(req), .o_mode(mode), .o_key(key),
    .o_sub(sub));
  initial begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) cyc <= i_reset ? 0 : cyc + 1;
  task automatic ck(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (x !== g) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic rc(input logic [1:0] m, input logic [15:0] k, input logic [7:0] s, input logic xe,
    input logic [7:0] xd);
    i_host.rd(m, k, s, e, d);
    ck("refused", {31'h0, xe}, {31'h0, e});
    ck("valid", {31'h0, ~xe}, {31'h0, vld});
    ck("byte", {24'h0, xd}, {24'h0, d});
  endtask
  // Reads the four timestamp bytes, low byte first
  task automatic rs(output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      i_host.rd(2'h0, 16'h0001, 8'h10 + 8'(i), e, d);
      v[8*i +: 8] = d;
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50us;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rc(2'h0, 16'h0001, 8'h01, 1'b0, 8'h15);
    rc(2'h0, 16'h0001, 8'h04, 1'b0, 8'h71);
    rc(2'h0, 16'h0001, 8'h05, 1'b0, 8'h08);
    rc(2'h0, 16'h0001, 8'h06, 1'b0, 8'h04);
    rc(2'h0, 16'h0001, 8'h0C, 1'b0, 8'h00);
    rc(2'h0, 16'h0001, 8'h21, 1'b1, 8'h00);
    rc(2'h0, 16'h0101, 8'h00, 1'b1, 8'h00);
    rc(2'h0, 16'h0002, 8'h00, 1'b1, 8'h00);
    rc(2'h0, 16'h0000, 8'h04, 1'b1, 8'h00);
    rc(2'h3, 16'h0001, 8'h00, 1'b1, 8'h00);
    rc(2'h1, 16'h2F01, 8'h06, 1'b0, 8'h04);
    rc(2'h1, 16'h2F00, 8'h04, 1'b1, 8'h00);
    rc(2'h1, 16'h2F02, 8'h00, 1'b1, 8'h00);
    rc(2'h2, 16'h5005, 8'h03, 1'b0, 8'h15);
    rc(2'h2, 16'h5005, 8'h06, 1'b0, 8'h71);
    rc(2'h2, 16'h5005, 8'h01, 1'b1, 8'h00);
    rc(2'h2, 16'h5005, 8'h16, 1'b1, 8'h00);
    rc(2'h2, 16'h5006, 8'h03, 1'b1, 8'h00);
    und <= 4'h4;
    t0 = (cyc + 1) / drb_pkg::TICK_CYCLES;
    rc(2'h0, 16'h0001, 8'h0A, 1'b0, 8'h40);
    rc(2'h0, 16'h0001, 8'h07, 1'b0, 8'h04);
    ck("led", 32'h4, {28'h0, led});
    rs(ts);
    ck("stamp", 32'(t0), ts);
    flg <= 7'h7F;
    cfg <= 4'h1;
    ovr <= 4'h8;
    rc(2'h0, 16'h0001, 8'h00, 1'b0, 8'h9F);
    rc(2'h0, 16'h0000, 8'h03, 1'b0, 8'h18);
    rc(2'h0, 16'h0001, 8'h08, 1'b0, 8'h01);
    rc(2'h0, 16'h0001, 8'h0B, 1'b0, 8'h80);
    rc(2'h0, 16'h0001, 8'h07, 1'b0, 8'h0D);
    ck("led", 32'hD, {28'h0, led});
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rs(ts);
    ck("stamp after reset", 32'h0, ts);
    end_of_test();
  end
endmodule // drb_bank_test
`default_nettype wire
